//--- hw/fsp_pkg.sv
// flash self-programming control: shared constants and types
// assumes a 20 MHz system clock and an AXI4-Lite register master
package fsp_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFS     = 8'h00; // self_prog_control_reg
   localparam logic [7:0]  ZPTR_OFS     = 8'h04; // flash address pointer
   localparam logic [7:0]  DATA_OFS     = 8'h08; // data_word_registers
   localparam logic [7:0]  INSN_OFS     = 8'h0c; // instruction strobe / result
   localparam logic [7:0]  STAT_OFS     = 8'h10; // status
   localparam logic [7:0]  PAGE_OFS     = 8'h14; // programmed page index
   // ------------------------------------------------------------
   // control bit positions
   // ------------------------------------------------------------
   localparam int EN_BIT   = 0;
   localparam int ERS_BIT  = 1;
   localparam int WRT_BIT  = 2;
   localparam int LFR_BIT  = 3;
   localparam int RWW_BIT  = 4;
   localparam int BUSY_BIT = 6;
   localparam logic [4:0] CODE_RWW  = 5'h11;
   localparam logic [4:0] CODE_LFR  = 5'h09;
   localparam logic [4:0] CODE_WRT  = 5'h05;
   localparam logic [4:0] CODE_ERS  = 5'h03;
   localparam logic [4:0] CODE_LOAD = 5'h01;
   // instruction strobe bits in INSN register
   localparam int STORE_BIT = 0;
   localparam int LOAD_BIT  = 1;
   // ------------------------------------------------------------
   // address fields
   // ------------------------------------------------------------
   localparam int WORD_BITS = 5;  // 32 words per page
   localparam int PAGE_LSB  = WORD_BITS + 1;
   localparam int PAGE_BITS = 16 - PAGE_LSB;
   localparam int PAGE_WORDS = 1 << WORD_BITS;
   // readout pointer values
   localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
   localparam logic [15:0] Z_LOCK      = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT  = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ       = 20_000_000;
   localparam int STORE_WIN    = 4;
   localparam int LOAD_WIN     = 3;
   localparam int PROG_MIN_US  = 3700;
   localparam int PROG_MAX_US  = 4500;
   // aim inside the window: midpoint in whole microseconds, times cycles per microsecond
   localparam int PROG_CYCLES  =
      ((PROG_MIN_US + PROG_MAX_US) / 2) * (CLK_HZ / 1_000_000);
   localparam int OSC_DIV      = 20; // calibrated 1 MHz tick
   localparam int PROG_TICKS   = (PROG_MIN_US + PROG_MAX_US) / 2;
   typedef enum logic [1:0] {
      FSP_IDLE  = 2'b00,
      FSP_ARMED = 2'b01,
      FSP_PROG  = 2'b11
   } fsp_state_t;
endpackage

//--- hw/fsp_osc_tick.sv
// calibrated oscillator tick divider
// assumes one system clock; emits a one-cycle enable every div cycles
`timescale 1ns/1ns
`default_nettype none
module fsp_osc_tick
(
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   logic [4:0] cnt_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_q <= 5'h00;
         tick  <= 1'b0;
      end
      else
      begin
         tick <= (cnt_q == 5'(fsp_pkg::OSC_DIV - 1));
         if (cnt_q == 5'(fsp_pkg::OSC_DIV - 1))
            cnt_q <= 5'h00;
         else
            cnt_q <= cnt_q + 5'h01;
      end
   end
endmodule // fsp_osc_tick
`default_nettype wire

//--- hw/fsp_ctrl.sv
// flash self-programming control, top level
// assumes AXI4-Lite master on aclk; eeprom busy and fuses from outside
//
// Function
// - cpu is halted for the whole page write
// - eeprom write during buffer loading discards loaded words
// - pointer: low bits word in page, high bits page
// - load-program reads bytewise, pointer bit zero selects byte
// - eeprom write in progress blocks flash programming; only arming checks it, an armed erase or write store still starts
// - eeprom write in progress blocks fuse and lock readout
// - lock readout: pointer 0x0001, load within three returns bits 1:0
// - select and enable self-clear after readout or window expiry
// - with select clear, load reads ordinary program bytes
// - armed readout with pointer 0x0000 returns low fuse byte
// - armed readout with pointer 0x0003 returns high fuse byte
// - armed readout with pointer 0x0002 returns extended fuse byte
// - programmed bits read zero, unprogrammed read one
// - reset during flash write still completes the write
// - erase, write, lock write last 3.7 to 4.5 ms from oscillator; no lock write here, erase and write take 4.1 ms
// - rww busy flag always reads zero
// - buffer load: word index selects slot, one write per slot until a page write, rww store or eeprom write clears it
// - other low five control codes are ignored
// - enable arms store four cycles; held until erase or write ends
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module fsp_ctrl
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        eeprom_write_busy,
   input  wire logic [7:0]  fuse_low_byte,
   input  wire logic [7:0]  fuse_high_byte,
   input  wire logic [7:0]  extended_fuse_byte,
   input  wire logic [1:0]  lock_bits,
   input  wire logic [15:0] prog_rd_word,
   output logic [15:0]      prog_rd_addr,
   output logic             cpu_halt,
   output logic             flash_erase,
   output logic             flash_write,
   output logic [9:0]       flash_page
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic       ee_s1_q, ee_s2_q;
   logic [7:0] fl_s1_q, fl_s2_q, fh_s1_q, fh_s2_q, fe_s1_q, fe_s2_q;
   logic [1:0] lk_s1_q, lk_s2_q;
   always_ff @(posedge aclk)
   begin
      ee_s1_q <= eeprom_write_busy;
      ee_s2_q <= ee_s1_q;
      fl_s1_q <= fuse_low_byte;
      fl_s2_q <= fl_s1_q;
      fh_s1_q <= fuse_high_byte;
      fh_s2_q <= fh_s1_q;
      fe_s1_q <= extended_fuse_byte;
      fe_s2_q <= fe_s1_q;
      lk_s1_q <= lock_bits;
      lk_s2_q <= lk_s1_q;
   end
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fsp_pkg::fsp_state_t state_q;
   logic [4:0]  ctrl_q;
   logic [15:0] zptr_q;
   logic [15:0] data_q;
   logic [7:0]  result_q;
   logic [2:0]  win_q;
   logic [12:0] prog_cnt_q;
   localparam int PAGE_W = fsp_pkg::PAGE_BITS;
   logic [PAGE_W-1:0] page_q;
   logic [15:0] buf_q [fsp_pkg::PAGE_WORDS];
   logic [fsp_pkg::PAGE_WORDS-1:0] buf_full_q;
   logic        osc_tick;
   fsp_osc_tick u_tick
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (osc_tick)
   );
   // ------------------------------------------------------------
   // axi write channel
   // ------------------------------------------------------------
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic        wr_go;
   assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end
      else
      begin
         s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q[7:2] > fsp_pkg::PAGE_OFS[7:2]) ? 2'b10 : 2'b00;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // decoded write strobes
   logic wr_ctrl, wr_zptr, wr_data, wr_insn, do_store, do_load;
   assign wr_ctrl  = wr_go && aw_addr_q == fsp_pkg::CTRL_OFS;
   assign wr_zptr  = wr_go && aw_addr_q == fsp_pkg::ZPTR_OFS;
   assign wr_data  = wr_go && aw_addr_q == fsp_pkg::DATA_OFS;
   assign wr_insn  = wr_go && aw_addr_q == fsp_pkg::INSN_OFS;
   assign do_store = wr_insn && w_data_q[fsp_pkg::STORE_BIT];
   assign do_load  = wr_insn && w_data_q[fsp_pkg::LOAD_BIT];
   // ------------------------------------------------------------
   // control register and sequencer
   // ------------------------------------------------------------
   logic code_ok;
   logic [4:0] code;
   assign code    = w_data_q[4:0];
   assign code_ok = code == fsp_pkg::CODE_RWW || code == fsp_pkg::CODE_LFR ||
                    code == fsp_pkg::CODE_WRT || code == fsp_pkg::CODE_ERS ||
                    code == fsp_pkg::CODE_LOAD;
   logic prog_done;
   assign prog_done = state_q == fsp_pkg::FSP_PROG && osc_tick && prog_cnt_q == 13'h0001;
   always_ff @(posedge aclk)
   begin
      // a write in progress ignores reset and runs to completion
      if (!aresetn && state_q != fsp_pkg::FSP_PROG)
      begin
         state_q    <= fsp_pkg::FSP_IDLE;
         ctrl_q     <= 5'h00;
         win_q      <= 3'h0;
         prog_cnt_q <= 13'h0000;
         flash_erase <= 1'b0;
         flash_write <= 1'b0;
         cpu_halt   <= 1'b0;
      end
      else
      begin
         flash_erase <= 1'b0;
         flash_write <= 1'b0;
         unique case (state_q)
            fsp_pkg::FSP_IDLE:
            begin
               if (wr_ctrl && code_ok && !ee_s2_q)
               begin
                  ctrl_q  <= code;
                  win_q   <= 3'(fsp_pkg::STORE_WIN);
                  state_q <= fsp_pkg::FSP_ARMED;
               end
            end
            fsp_pkg::FSP_ARMED:
            begin
               // windows open once the control write's response is taken
               if (!s_axi_bvalid)
                  win_q <= win_q - 3'h1;
               if (do_store && (ctrl_q == fsp_pkg::CODE_ERS || ctrl_q == fsp_pkg::CODE_WRT))
               begin
                  flash_erase <= ctrl_q == fsp_pkg::CODE_ERS;
                  flash_write <= ctrl_q == fsp_pkg::CODE_WRT;
                  prog_cnt_q  <= 13'(fsp_pkg::PROG_TICKS);
                  cpu_halt    <= 1'b1;
                  state_q     <= fsp_pkg::FSP_PROG;
               end
               else if (do_store || do_load || win_q == 3'h1 ||
                        (ctrl_q[fsp_pkg::LFR_BIT] && win_q ==
                         3'(fsp_pkg::STORE_WIN - fsp_pkg::LOAD_WIN + 1) && !do_load))
               begin
                  ctrl_q  <= 5'h00;
                  state_q <= fsp_pkg::FSP_IDLE;
               end
            end
            fsp_pkg::FSP_PROG:
            begin
               if (osc_tick)
                  prog_cnt_q <= prog_cnt_q - 13'h0001;
               if (prog_done)
               begin
                  ctrl_q   <= 5'h00;
                  cpu_halt <= 1'b0;
                  state_q  <= fsp_pkg::FSP_IDLE;
               end
            end
            default:
               state_q <= fsp_pkg::FSP_IDLE;
         endcase
      end
   end
   // ------------------------------------------------------------
   // pointer, data and page latch
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         zptr_q <= 16'h0000;
         data_q <= 16'h0000;
      end
      else
      begin
         if (wr_zptr && !cpu_halt)
            zptr_q <= w_data_q[15:0];
         if (wr_data && !cpu_halt)
            data_q <= w_data_q[15:0];
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn && state_q != fsp_pkg::FSP_PROG)
         page_q <= '0;
      else if (state_q == fsp_pkg::FSP_ARMED && do_store)
         page_q <= zptr_q[15:fsp_pkg::PAGE_LSB];
   end
   assign flash_page = page_q;
   // ------------------------------------------------------------
   // temporary page buffer
   // ------------------------------------------------------------
   logic store_word, buf_clear;
   logic flash_write_q;
   assign store_word = state_q == fsp_pkg::FSP_ARMED && do_store &&
                       ctrl_q == fsp_pkg::CODE_LOAD;
   assign buf_clear  = ee_s2_q || prog_done && flash_write_q ||
                       (state_q == fsp_pkg::FSP_ARMED && do_store &&
                        ctrl_q == fsp_pkg::CODE_RWW);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flash_write_q <= 1'b0;
      else if (flash_write)
         flash_write_q <= 1'b1;
      else if (prog_done)
         flash_write_q <= 1'b0;
   end
   genvar gi;
   generate
      for (gi = 0; gi < fsp_pkg::PAGE_WORDS; gi++)
      begin : g_buf
         always_ff @(posedge aclk)
         begin
            if (!aresetn || buf_clear)
            begin
               buf_full_q[gi] <= 1'b0;
               buf_q[gi]      <= 16'h0000;
            end
            else if (store_word && !buf_full_q[gi] &&
                     zptr_q[fsp_pkg::PAGE_LSB-1:1] == 5'(gi))
            begin
               buf_full_q[gi] <= 1'b1;
               buf_q[gi]      <= data_q;
            end
         end
      end
   endgenerate
   // ------------------------------------------------------------
   // load-program result
   // ------------------------------------------------------------
   logic lfr_armed;
   assign lfr_armed = state_q == fsp_pkg::FSP_ARMED && ctrl_q == fsp_pkg::CODE_LFR;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         result_q     <= 8'h00;
         prog_rd_addr <= 16'h0000;
      end
      else
      begin
         prog_rd_addr <= {1'b0, zptr_q[15:1]};
         if (do_load && lfr_armed && !ee_s2_q)
         begin
            unique case (zptr_q)
               fsp_pkg::Z_FUSE_LOW:  result_q <= fl_s2_q;
               fsp_pkg::Z_LOCK:      result_q <= {6'h3f, lk_s2_q};
               fsp_pkg::Z_FUSE_EXT:  result_q <= fe_s2_q;
               fsp_pkg::Z_FUSE_HIGH: result_q <= fh_s2_q;
               default:              result_q <= 8'hff;
            endcase
         end
         else if (do_load)
            result_q <= zptr_q[0] ? prog_rd_word[15:8] : prog_rd_word[7:0];
      end
   end
   // ------------------------------------------------------------
   // axi read channel
   // ------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (s_axi_araddr)
         fsp_pkg::CTRL_OFS: rd_mux = {27'h0, ctrl_q};
         fsp_pkg::ZPTR_OFS: rd_mux = {16'h0000, zptr_q};
         fsp_pkg::DATA_OFS: rd_mux = {16'h0000, data_q};
         fsp_pkg::INSN_OFS: rd_mux = {24'h00_0000, result_q};
         fsp_pkg::STAT_OFS: rd_mux = {28'h0, |buf_full_q, ee_s2_q, cpu_halt,
                                      state_q != fsp_pkg::FSP_IDLE};
         fsp_pkg::PAGE_OFS: rd_mux = {22'h0, page_q};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= (s_axi_araddr[7:2] > fsp_pkg::PAGE_OFS[7:2] ||
                              s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_prog_halts: assert property (@(posedge aclk)
      $rose(state_q == fsp_pkg::FSP_PROG) |-> cpu_halt)
      else $error("cpu not halted during programming");
   a_ee_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == fsp_pkg::FSP_IDLE && ee_s2_q) |=> state_q == fsp_pkg::FSP_IDLE)
      else $error("arming while eeprom busy");
   a_bad_code: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == fsp_pkg::FSP_IDLE && wr_ctrl && !code_ok) |=> ctrl_q == 5'h00)
      else $error("illegal code accepted");
   a_store_win: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_q == fsp_pkg::FSP_ARMED && $fell(s_axi_bvalid))
      |-> ##[1:4] state_q != fsp_pkg::FSP_ARMED)
      else $error("arm window too long");
   a_ee_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      ee_s2_q |=> buf_full_q == '0)
      else $error("buffer kept during eeprom write");
   a_en_held: assert property (@(posedge aclk) disable iff (!aresetn)
      state_q == fsp_pkg::FSP_PROG |-> ctrl_q[fsp_pkg::EN_BIT])
      else $error("enable dropped in operation");
   a_lock_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_load && lfr_armed && !ee_s2_q && zptr_q == fsp_pkg::Z_LOCK)
      |=> result_q[1:0] == $past(lk_s2_q))
      else $error("lock bits wrong");
   a_byte_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_load && state_q == fsp_pkg::FSP_IDLE && zptr_q[0])
      |=> result_q == $past(prog_rd_word[15:8]))
      else $error("byte select wrong");
   c_erase: cover property (@(posedge aclk) flash_erase);
   c_write: cover property (@(posedge aclk) flash_write);
   c_fuse:  cover property (@(posedge aclk) do_load && lfr_armed);
endmodule // fsp_ctrl
`default_nettype wire

//--- test/fsp_prog_mem_model.sv
// program memory model for the self-programming bench
// assumes a combinational word read at the word address
`timescale 1ns/1ns
`default_nettype none
module fsp_prog_mem_model
(
   input  wire logic [15:0] prog_rd_addr,
   output logic      [15:0] prog_rd_word
);
   // high byte differs from low so the byte select shows
   assign prog_rd_word = {prog_rd_addr[7:0] ^ 8'h3c, prog_rd_addr[7:0]};
endmodule // fsp_prog_mem_model
`default_nettype wire

//--- test/flash_self_program_control_test.sv
// self-checking bench for the flash self-programming control
// assumes the AXI4-Lite master here and the program memory model
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_control_test;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, ee_busy = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        cpu_halt, flash_erase, flash_write;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] rd_addr, rd_word;
   logic [9:0]  page;
   logic [7:0]  f_lo = 8'ha6, f_hi = 8'h5b, f_ex = 8'hf9;
   logic [1:0]  lock = 2'b10;
   logic        ers_seen = 1'b0, wr_seen = 1'b0;
   int          mismatches = 0, cmp_count = 0, halt_cnt = 0;

   always #25 aclk = ~aclk;
   always @(posedge aclk)
   begin
      if (cpu_halt === 1'b1) halt_cnt <= halt_cnt + 1;
      if (flash_erase === 1'b1) ers_seen <= 1'b1;
      if (flash_write === 1'b1) wr_seen <= 1'b1;
   end

   fsp_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .eeprom_write_busy(ee_busy), .fuse_low_byte(f_lo),
      .fuse_high_byte(f_hi), .extended_fuse_byte(f_ex), .lock_bits(lock),
      .prog_rd_word(rd_word), .prog_rd_addr(rd_addr), .cpu_halt(cpu_halt),
      .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(page));
   fsp_prog_mem_model u_mem (.prog_rd_addr(rd_addr), .prog_rd_word(rd_word));

   // ------------------------------------------------------------
   // bus tasks and checking
   // ------------------------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic hang();
      mismatches++;
      $display("[ERR] wait expected done seen timeout");
      test_done();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 40)
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1)
         begin
            bready <= 1'b0;
            n = 99;
         end
         n++;
      end
      if (n < 99) hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 40)
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            n = 99;
         end
         n++;
      end
      if (n < 99) hang();
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  ev [4];
      int          w;
      ev = '{f_lo, {6'h0, lock}, f_ex, f_hi};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("ctrl_reset", 32'h0, d);
      rd(8'h40, d, r);
      chk("unmapped_resp", 32'h2, {30'h0, r});
      for (int i = 0; i < 4; i++)
      begin
         wr(fsp_pkg::ZPTR_OFS, i);
         wr(fsp_pkg::CTRL_OFS, 32'h9);
         wr(fsp_pkg::INSN_OFS, 32'h2);
         rd(fsp_pkg::INSN_OFS, d, r);
         chk("readout", {24'h0, ev[i]}, (i == 1) ? {30'h0, d[1:0]} : {24'h0, d[7:0]});
      end
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("ctrl_after_read", 32'h0, {27'h0, d[4:0]});
      wr(fsp_pkg::ZPTR_OFS, 32'h3);
      wr(fsp_pkg::CTRL_OFS, 32'h9);
      repeat (6) @(posedge aclk);
      wr(fsp_pkg::INSN_OFS, 32'h2);
      rd(fsp_pkg::INSN_OFS, d, r);
      chk("late_load", 32'h3d, {24'h0, d[7:0]});
      wr(fsp_pkg::CTRL_OFS, 32'h1);
      repeat (6) @(posedge aclk);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("store_window", 32'h0, {27'h0, d[4:0]});
      wr(fsp_pkg::CTRL_OFS, 32'h7);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("illegal_code", 32'h0, {27'h0, d[4:0]});
      ee_busy <= 1'b1;
      repeat (4) @(posedge aclk);
      wr(fsp_pkg::ZPTR_OFS, 32'h1);
      wr(fsp_pkg::CTRL_OFS, 32'h9);
      wr(fsp_pkg::INSN_OFS, 32'h2);
      rd(fsp_pkg::INSN_OFS, d, r);
      chk("blocked_read", 32'h3c, {24'h0, d[7:0]});
      wr(fsp_pkg::CTRL_OFS, 32'h3);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("blocked_prog", 32'h0, {27'h0, d[4:0]});
      ee_busy <= 1'b0;
      repeat (4) @(posedge aclk);
      // page 5 erase, reset dropped in mid-operation
      wr(fsp_pkg::ZPTR_OFS, 32'h0140);
      wr(fsp_pkg::CTRL_OFS, 32'h3);
      wr(fsp_pkg::INSN_OFS, 32'h1);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("enable_held", 32'h3, {30'h0, d[1:0]});
      chk("halt", 32'h1, {31'h0, cpu_halt});
      chk("erase_page", 32'h5, {22'h0, page});
      repeat (20000) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk("halt_in_reset", 32'h1, {31'h0, cpu_halt});
      w = 0;
      while (cpu_halt === 1'b1 && w < 70000)
      begin
         @(posedge aclk);
         w++;
      end
      if (w >= 70000) hang();
      chk("erase_pulse", 32'h1, {31'h0, ers_seen});
      chk("prog_time", 32'h1, {31'h0, halt_cnt >= 74000 && halt_cnt <= 90000});
      repeat (2) @(posedge aclk);
      rd(fsp_pkg::CTRL_OFS, d, r);
      chk("ctrl_done", 32'h0, {27'h0, d[4:0]});
      // one buffer word, then dropped by an eeprom write
      wr(fsp_pkg::DATA_OFS, 32'h1234);
      wr(fsp_pkg::ZPTR_OFS, 32'h0142);
      wr(fsp_pkg::CTRL_OFS, 32'h1);
      wr(fsp_pkg::INSN_OFS, 32'h1);
      rd(fsp_pkg::STAT_OFS, d, r);
      chk("buf_loaded", 32'h1, {31'h0, d[3]});
      ee_busy <= 1'b1;
      repeat (4) @(posedge aclk);
      ee_busy <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(fsp_pkg::STAT_OFS, d, r);
      chk("buf_dropped", 32'h0, {31'h0, d[3]});
      // page write to the erased page; run ends while it is timed
      wr(fsp_pkg::ZPTR_OFS, 32'h0140);
      wr(fsp_pkg::CTRL_OFS, 32'h5);
      wr(fsp_pkg::INSN_OFS, 32'h1);
      rd(fsp_pkg::STAT_OFS, d, r);
      chk("write_halt", 32'h1, {31'h0, d[1]});
      chk("write_pulse", 32'h1, {31'h0, wr_seen});
      chk("write_page", 32'h5, {22'h0, page});
      test_done();
   end
endmodule // flash_self_program_control_test
`default_nettype wire
